/* File: instr_ocm_cfg_bus_ram_access_bench.sv */
`default_nettype none
module instr_ocm_cfg_bus_ram_access_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic fam = 1'b0;
	logic req = 1'b0;
	logic we = 1'b0;
	logic fen = 1'b1;
	logic [1:0] rsel = 2'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] faddr = 32'h0;
	logic [20:0] fa = 21'h00012;
	logic ack, hit;
	logic [31:0] rd;
	logic [20:0] ma;
	logic [63:0] fd;
	int n_errors = 0;
	int num_checks = 0;
	iocm_if link_if ();
	iocm_ctrl iocm_ctrl_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_req_i(req),
		.cfg_we_i(we), .cfg_reg_i(rsel), .cfg_wdata_i(wd), .cfg_ack_o(ack), .cfg_rdata_o(rd),
		.fetch_addr_i(faddr), .fetch_hit_o(hit), .fetch_mem_addr_o(ma), .link(link_if));
	iocm_fabric iocm_fabric_inst (.clk_i(clk_i), .resetn_i(resetn_i), .new_family_i(fam),
		.link(link_if), .fetch_en_i(fen), .fetch_addr_i(fa), .fetch_data_o(fd));
	iocm_props iocm_props_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.memory_write_address_bus(link_if.memory_write_address_bus),
		.memory_write_data_bus(link_if.memory_write_data_bus),
		.even_word_write_enable(link_if.even_word_write_enable),
		.odd_word_write_enable(link_if.odd_word_write_enable),
		.even_bank_enable(link_if.even_bank_enable), .odd_bank_enable(link_if.odd_bank_enable),
		.word_read_select(link_if.word_read_select), .cfg_read_data(link_if.cfg_read_data));
	// Clock at 250 MHz
	always #2 clk_i = ~clk_i;
	// Compare and count
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One request on the configuration bus, waiting for its ack
	task automatic acc(input logic w, input logic [1:0] r, input logic [31:0] d);
		@(negedge clk_i);
		req = 1'b1;
		we = w;
		rsel = r;
		wd = d;
		@(negedge clk_i);
		req = 1'b0;
		for (int i = 0; i < 8 && ack !== 1'b1; i++)
			@(negedge clk_i);
		chk({63'h0, ack}, 64'h1);
	endtask : acc
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	// Watchdog
	initial
	begin
		#20000;
		n_errors++;
		test_done();
	end
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_i);
		@(negedge clk_i) resetn_i = 1'b1;
		acc(1'b0, iocm_pkg::REG_BASE, 32'h0);
		chk(rd, 64'hff);
		acc(1'b1, iocm_pkg::REG_BASE, 32'h5a);
		acc(1'b0, iocm_pkg::REG_BASE, 32'h0);
		chk(rd, 64'h5a);
		faddr = 32'h5a3456f8;
		@(negedge clk_i) chk({hit, ma}, {1'b1, 21'h068adf});
		faddr = 32'h5b3456f8;
		@(negedge clk_i) chk(hit, 64'h0);
		$display("base decode test done");
		for (int f = 0; f < 2; f++)
		begin
			fam = f[0];
			fa = 21'h00012 + 21'(f);
			for (int h = 0; h < 2; h++)
			begin
				acc(1'b1, iocm_pkg::REG_INIT, {10'h0, fa, h[0]});
				acc(1'b1, iocm_pkg::REG_FILL, 32'h5ac30000 + 32'(2 * f + h));
				acc(1'b1, iocm_pkg::REG_DATA, 32'h0);
			end
			acc(1'b0, iocm_pkg::REG_FILL, 32'h0);
			chk(rd, 32'h5ac30001 + 32'(2 * f));
			acc(1'b0, iocm_pkg::REG_INIT, 32'h0);
			chk(rd, {10'h0, fa, 1'b1});
			repeat (3) @(negedge clk_i);
			chk(fd, {32'h5ac30001 + 32'(2 * f), 32'h5ac30000 + 32'(2 * f)});
			for (int h = 0; h < 2 && f == 1; h++)
			begin
				acc(1'b1, iocm_pkg::REG_INIT, {10'h0, fa, h[0]});
				acc(1'b0, iocm_pkg::REG_DATA, 32'h0);
				chk(rd, 32'h5ac30002 + 32'(h));
			end
			$display("memory test done for family %0d", f);
		end
		test_done();
	end
endmodule : instr_ocm_cfg_bus_ram_access_bench
`default_nettype wire

/* File: iocm_ctrl.sv */
`default_nettype none
// What this block does
// - Even write enable qualifies even-bank writes only
// - Bank strobes serve dual-port attachment only
// - Older family: even write drives enable too
// - Newer family: even write to WE, enable to EN
// - Single-port memory may leave even write open
// - Odd bank enable qualifies odd-word accesses
// - Even bank enable qualifies even-word accesses
// - Fabric mux narrows 64-bit data by select
// - Select 1 picks odd, 0 picks even
// - Software reads and writes control registers
// - Base register compared with address bits 0:7
// - Base places controller in any 16 MB range
// - Instruction side presents 21 address bits
// - Odd write enable qualifies odd-bank writes
// - Write address starts at initial-address value
// - Write data starts at fill-data value, both banks
module iocm_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Configuration register bus
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic [1:0] cfg_reg_i,
	input wire logic [iocm_pkg::CFG_DW-1:0] cfg_wdata_i,
	output logic cfg_ack_o,
	output logic [iocm_pkg::CFG_DW-1:0] cfg_rdata_o,
	// Address decode for fetches
	input wire logic [iocm_pkg::ADDR_W-1:0] fetch_addr_i,
	output logic fetch_hit_o,
	output logic [iocm_pkg::MEM_AW-1:0] fetch_mem_addr_o,
	// Memory link
	iocm_if.ctrl link
);
	// Control registers and the word half
	logic [iocm_pkg::BASE_W-1:0] base_r;
	logic [iocm_pkg::MEM_AW-1:0] init_r;
	logic [iocm_pkg::CFG_DW-1:0] fill_r;
	logic half_r;
	// Sequencer state and read-back word
	iocm_pkg::iocm_state_e state_r;
	iocm_pkg::iocm_state_e state_nxt;
	logic [iocm_pkg::CFG_DW-1:0] rdata_r;
	// Second read cycle: in the newer family the bank output register is loaded by now
	logic rd_wait_r;
	// Registered decode results
	logic fetch_hit_r;
	logic [iocm_pkg::MEM_AW-1:0] fetch_mem_addr_r;
	// Request decode
	logic idle;
	logic take;
	logic reg_wr;
	logic reg_rd;
	logic go_data;
	logic bank_cycle;
	logic even_sel;
	logic odd_sel;

	// A request is only taken while the sequencer rests; later ones are dropped
	assign idle = (state_r == iocm_pkg::ST_IDLE);
	assign take = cfg_req_i && idle;
	assign reg_wr = take && cfg_we_i;
	assign reg_rd = take && !cfg_we_i;
	assign go_data = take && (cfg_reg_i == iocm_pkg::REG_DATA);

	// The bank strobes are live for exactly one cycle per memory access
	assign bank_cycle = (state_r == iocm_pkg::ST_WRITE)
		|| (state_r == iocm_pkg::ST_READ && !rd_wait_r);
	assign even_sel = (half_r == iocm_pkg::SEL_EVEN);
	assign odd_sel = (half_r == iocm_pkg::SEL_ODD);

	// Control registers written by software
	// Writes while an access runs are dropped, so software waits for the ack
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			base_r <= iocm_pkg::BASE_RST;
			init_r <= iocm_pkg::INIT_RST;
			fill_r <= iocm_pkg::FILL_RST;
		end
		else if (reg_wr)
		begin
			case (cfg_reg_i)
				iocm_pkg::REG_BASE: base_r <= cfg_wdata_i[iocm_pkg::BASE_W-1:0];
				iocm_pkg::REG_INIT: init_r <= cfg_wdata_i[iocm_pkg::MEM_AW:1];
				iocm_pkg::REG_FILL: fill_r <= cfg_wdata_i;
				default: ;
			endcase
		end
	end

	// Word half: bit 0 of the initial address names the odd word
	// The half also steers the fabric's narrowing multiplexer
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			half_r <= iocm_pkg::SEL_EVEN;
		else if (reg_wr && cfg_reg_i == iocm_pkg::REG_INIT)
			half_r <= cfg_wdata_i[0];
	end

	// Next state: a data access strobes the bank, anything else answers at once
	// A request that arrives while busy is neither taken nor remembered
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			iocm_pkg::ST_IDLE:
			begin
				if (go_data)
					state_nxt = cfg_we_i ? iocm_pkg::ST_WRITE : iocm_pkg::ST_READ;
				else if (cfg_req_i)
					state_nxt = iocm_pkg::ST_DONE;
			end
			iocm_pkg::ST_WRITE: state_nxt = iocm_pkg::ST_DONE;
			// The bank output register needs one more edge before it can be read
			iocm_pkg::ST_READ:
			begin
				if (rd_wait_r)
					state_nxt = iocm_pkg::ST_DONE;
			end
			iocm_pkg::ST_DONE: state_nxt = iocm_pkg::ST_IDLE;
			default: state_nxt = iocm_pkg::ST_IDLE;
		endcase
	end

	// Sequencer state
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			state_r <= iocm_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Marks the second read cycle, in which the newer family's selected bank word is valid
	// Without it the read-back would catch the bank output one edge too early
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rd_wait_r <= 1'b0;
		else
			rd_wait_r <= (state_r == iocm_pkg::ST_READ) && !rd_wait_r;
	end

	// Bank strobes of the selected half only; the other bank stays idle
	// Strobes are decoded from registers only, so they carry no glitch from the bus
	always_comb
	begin
		link.even_word_write_enable = (state_r == iocm_pkg::ST_WRITE) && even_sel;
		link.odd_word_write_enable = (state_r == iocm_pkg::ST_WRITE) && odd_sel;
		link.even_bank_enable = bank_cycle && even_sel;
		link.odd_bank_enable = bank_cycle && odd_sel;
	end

	// Address, data and select toward the memory; all come straight from registers
	// The fabric writes only the bank whose strobe is up, so both banks share data
	assign link.memory_write_address_bus = init_r;
	assign link.memory_write_data_bus = fill_r;
	assign link.word_read_select = half_r;

	// Read-back: registers at the taking edge, memory words in the second read cycle
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_r <= '0;
		else if (reg_rd)
		begin
			case (cfg_reg_i)
				iocm_pkg::REG_BASE:
					rdata_r <= {{(iocm_pkg::CFG_DW-iocm_pkg::BASE_W){1'b0}}, base_r};
				iocm_pkg::REG_INIT:
					rdata_r <= {{(iocm_pkg::CFG_DW-iocm_pkg::MEM_AW-1){1'b0}}, init_r, half_r};
				iocm_pkg::REG_FILL: rdata_r <= fill_r;
				default: rdata_r <= rdata_r;
			endcase
		end
		else if (state_r == iocm_pkg::ST_READ && rd_wait_r)
			rdata_r <= link.cfg_read_data;
	end

	// Acknowledge stands for the one cycle spent in the done state
	assign cfg_rdata_o = rdata_r;
	assign cfg_ack_o = (state_r == iocm_pkg::ST_DONE);

	// Base decode: address bits 0:7 against the base, bits 8:28 to the memory
	// The low three bits pick a byte within the 64-bit word and are not passed on
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fetch_hit_r <= 1'b0;
			fetch_mem_addr_r <= '0;
		end
		else
		begin
			fetch_hit_r <= (fetch_addr_i[iocm_pkg::ADDR_W-1:iocm_pkg::BASE_LSB]
				== base_r);
			fetch_mem_addr_r <= fetch_addr_i[iocm_pkg::BASE_LSB-1:3];
		end
	end

	// The decode is registered, so a hit shows one cycle after the address
	assign fetch_hit_o = fetch_hit_r;
	assign fetch_mem_addr_o = fetch_mem_addr_r;
endmodule : iocm_ctrl
`default_nettype wire

/* File: iocm_fabric.sv */
`default_nettype none
module iocm_fabric (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Family choice: 1 for the newer family enable wiring
	input wire logic new_family_i,
	// Controller link
	iocm_if.fabric link,
	// Fetch port of the memory
	input wire logic fetch_en_i,
	input wire logic [iocm_pkg::MEM_AW-1:0] fetch_addr_i,
	output logic [iocm_pkg::MEM_DW-1:0] fetch_data_o
);
	localparam int DEPTH = 1 << iocm_pkg::MEM_AW;
	logic [iocm_pkg::CFG_DW-1:0] even_mem [DEPTH];
	logic [iocm_pkg::CFG_DW-1:0] odd_mem [DEPTH];
	logic [iocm_pkg::CFG_DW-1:0] even_q_r;
	logic [iocm_pkg::CFG_DW-1:0] odd_q_r;
	logic even_port_en;
	logic odd_port_en;

	// Port enable wiring per family
	assign even_port_en = new_family_i ? link.even_bank_enable
		: link.even_word_write_enable;
	assign odd_port_en = new_family_i ? link.odd_bank_enable
		: link.odd_word_write_enable;

	// Configuration port writes: only the bank whose write strobe is up takes the data
	always_ff @(posedge clk_i)
	begin
		if (even_port_en && link.even_word_write_enable)
			even_mem[link.memory_write_address_bus] <= link.memory_write_data_bus;
		if (odd_port_en && link.odd_word_write_enable)
			odd_mem[link.memory_write_address_bus] <= link.memory_write_data_bus;
	end

	// Bank output registers, write-first so a write shows its own word
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			even_q_r <= '0;
			odd_q_r <= '0;
		end
		else
		begin
			if (even_port_en)
				even_q_r <= link.even_word_write_enable ? link.memory_write_data_bus
					: even_mem[link.memory_write_address_bus];
			if (odd_port_en)
				odd_q_r <= link.odd_word_write_enable ? link.memory_write_data_bus
					: odd_mem[link.memory_write_address_bus];
		end
	end

	// Narrowing multiplexer to the configuration bus
	assign link.cfg_read_data = (link.word_read_select == iocm_pkg::SEL_ODD)
		? odd_q_r : even_q_r;

	// Fetch port returns both words and never looks at the write strobes
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			fetch_data_o <= '0;
		else if (fetch_en_i)
			fetch_data_o <= {odd_mem[fetch_addr_i], even_mem[fetch_addr_i]};
	end
endmodule : iocm_fabric
`default_nettype wire

/* File: iocm_if.sv */
`default_nettype none
interface iocm_if;
	logic [iocm_pkg::MEM_AW-1:0] memory_write_address_bus;
	logic [iocm_pkg::CFG_DW-1:0] memory_write_data_bus;
	logic even_word_write_enable;
	logic odd_word_write_enable;
	logic even_bank_enable;
	logic odd_bank_enable;
	logic word_read_select;
	logic [iocm_pkg::CFG_DW-1:0] cfg_read_data;
	// Controller end
	modport ctrl (
		output memory_write_address_bus, memory_write_data_bus,
		output even_word_write_enable, odd_word_write_enable,
		output even_bank_enable, odd_bank_enable, word_read_select,
		input cfg_read_data
	);
	// Fabric and memory end
	modport fabric (
		input memory_write_address_bus, memory_write_data_bus,
		input even_word_write_enable, odd_word_write_enable,
		input even_bank_enable, odd_bank_enable, word_read_select,
		output cfg_read_data
	);
endinterface : iocm_if
`default_nettype wire

/* File: iocm_pkg.sv */
`default_nettype none
package iocm_pkg;
	// Widths of the configuration bus and the memory paths
	localparam int CFG_DW = 32;
	localparam int MEM_DW = 64;
	localparam int MEM_AW = 21;
	localparam int BASE_W = 8;
	localparam int ADDR_W = 32;
	// Position of the base field in a processor address
	localparam int BASE_LSB = 24;
	// Index of the configuration registers of this controller
	localparam logic [1:0] REG_BASE = 2'h0;
	localparam logic [1:0] REG_INIT = 2'h1;
	localparam logic [1:0] REG_FILL = 2'h2;
	localparam logic [1:0] REG_DATA = 2'h3;
	// Reset values
	localparam logic [BASE_W-1:0] BASE_RST = 8'hff;
	localparam logic [MEM_AW-1:0] INIT_RST = 21'h00000;
	localparam logic [CFG_DW-1:0] FILL_RST = 32'h00000000;
	// Word select codes
	localparam logic SEL_EVEN = 1'b0;
	localparam logic SEL_ODD = 1'b1;
	// Access states
	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_DONE} iocm_state_e;
endpackage : iocm_pkg
`default_nettype wire

/* File: iocm_props.sv */
`default_nettype none
module iocm_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Link signals
	input wire logic [iocm_pkg::MEM_AW-1:0] memory_write_address_bus,
	input wire logic [iocm_pkg::CFG_DW-1:0] memory_write_data_bus,
	input wire logic even_word_write_enable,
	input wire logic odd_word_write_enable,
	input wire logic even_bank_enable,
	input wire logic odd_bank_enable,
	input wire logic word_read_select,
	input wire logic [iocm_pkg::CFG_DW-1:0] cfg_read_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	// Write strobes stay in the selected half
	a_even_write_half: assert property (even_word_write_enable |-> !odd_word_write_enable
		&& !odd_bank_enable && word_read_select == iocm_pkg::SEL_EVEN) else $error("even write");
	a_odd_write_half: assert property (odd_word_write_enable |-> !even_word_write_enable
		&& !even_bank_enable && word_read_select == iocm_pkg::SEL_ODD) else $error("odd write");
	// Bank enables follow the select
	a_odd_en_sel: assert property (odd_bank_enable |-> word_read_select)
		else $error("odd enable select");
	a_even_en_sel: assert property (even_bank_enable |-> !word_read_select)
		else $error("even enable select");
	// One strobe per access
	a_odd_en_pulse: assert property (odd_bank_enable |=> !odd_bank_enable)
		else $error("odd enable held");
	a_even_en_pulse: assert property ($rose(even_bank_enable) |=> !even_bank_enable)
		else $error("even enable held");
	// Address and data steady around an access
	a_addr_steady: assert property ((even_bank_enable || odd_bank_enable)
		|-> $stable(memory_write_address_bus)) else $error("address moved");
	a_data_steady: assert property (even_word_write_enable || odd_word_write_enable
		|-> $stable(memory_write_data_bus)) else $error("data moved");
	// Read word only moves after a bank access or a new select
	a_rdata_hold: assert property (!$past(even_bank_enable) && !$past(odd_bank_enable)
		&& $stable(word_read_select) |-> $stable(cfg_read_data)) else $error("read word moved");
endmodule : iocm_props
`default_nettype wire
